// ===== design/rfx_pkg.sv
package rfx_pkg;

  localparam int unsigned OUT_COUNT        = 8;
  localparam int unsigned FRAME_BITS       = 23;
  localparam int unsigned FRAME_EVAL_BIT   = 21;

  localparam logic [3:0]  USID_STRAP_HIGH  = 4'h9;
  localparam logic [3:0]  USID_STRAP_LOW   = 4'h1;
  localparam logic [3:0]  USID_BROADCAST   = 4'h0;
  localparam logic [2:0]  CMD_REG_WRITE    = 3'h2;

  localparam logic [4:0]  LINK_OUT_VALUE   = 5'h00;
  localparam logic [4:0]  LINK_UPD_MASK    = 5'h01;
  localparam logic [4:0]  LINK_PULL_DIR    = 5'h02;
  localparam logic [4:0]  LINK_PULL_ON     = 5'h03;
  localparam logic [4:0]  LINK_DRIVE_HIGH  = 5'h04;
  localparam logic [4:0]  LINK_TRIGGER     = 5'h1c;
  localparam int unsigned SOFT_RESET_BIT   = 6;

  localparam logic [7:0]  OUT_VALUE_RST    = 8'h00;
  localparam logic [7:0]  MASK_AUTO_RST    = 8'h00;
  localparam logic [7:0]  MASK_MANUAL_RST  = 8'hff;
  localparam logic [7:0]  PULL_DIR_RST     = 8'h00;
  localparam logic [7:0]  PULL_ON_RST      = 8'hff;
  localparam logic [7:0]  DRIVE_HIGH_RST   = 8'hff;
  localparam logic [7:0]  DRIVE_EN_RST     = 8'h00;

  localparam logic [7:0]  AHB_CTRL         = 8'h00;
  localparam logic [7:0]  AHB_STATUS       = 8'h04;
  localparam logic [7:0]  AHB_OUT_VALUE    = 8'h08;
  localparam logic [7:0]  AHB_UPD_MASK     = 8'h0c;
  localparam logic [7:0]  AHB_PULL_DIR     = 8'h10;
  localparam logic [7:0]  AHB_PULL_ON      = 8'h14;
  localparam logic [7:0]  AHB_DRIVE_HIGH   = 8'h18;
  localparam logic [7:0]  AHB_PIN_STATE    = 8'h1c;
  localparam logic        CTRL_LINK_EN_RST = 1'b1;

  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } rfx_wr_t;

  typedef struct packed {
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
    logic [7:0] oe;
    logic [7:0] level;
  } rfx_pins_t;

endpackage

// ===== design/rfx_sync2.sv
`timescale 1ns/1ns
module rfx_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule

// ===== design/rfx_link_rx.sv
`timescale 1ns/1ns
module rfx_link_rx
  import rfx_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       link_rst,
  input  wire logic       sdata,
  input  wire logic       link_en,
  input  wire logic [3:0] usid,
  output rfx_wr_t         wr_word_q,
  output logic            wr_toggle_q
);

  logic [4:0]  bit_cnt_q;
  logic [20:0] shift_q;
  logic [21:0] frame;
  logic        accept;

  assign frame = {shift_q, sdata};

  // Command half parity and data half parity are both odd.
  assign accept = link_en
                  && (frame[21:18] == usid || frame[21:18] == USID_BROADCAST)
                  && frame[17:15] == CMD_REG_WRITE
                  && (^frame[21:9])
                  && (^frame[8:0]);

  // The link clock stands still between frames, so the counter parks itself at zero after the bus park edge.
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q == 5'(FRAME_BITS - 1)) begin
      bit_cnt_q <= 5'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      shift_q <= 21'h000000;
    end else begin
      shift_q <= frame[20:0];
    end
  end

  // The word is held until the next accepted frame, so the other domain reads it stable after the toggle.
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      wr_word_q   <= '0;
      wr_toggle_q <= 1'b0;
    end else if (bit_cnt_q == 5'(FRAME_EVAL_BIT) && accept) begin
      wr_word_q   <= '{addr: frame[14:10], data: frame[8:1]};
      wr_toggle_q <= ~wr_toggle_q;
    end
  end

endmodule

// ===== design/rfx_expander.sv
// Function
// - Strap selects identifier 1001 or 0001.
// - Eight outputs: high, low, high-z, pulls.
// - Reset leaves outputs high-z, pull-down on.
// - Auto mode: value register starts unmasked.
// - Auto mode value write drives, drops pulls.
// - Auto mode ignores pull and high-z writes.
// - Auto mode still applies update mask.
// - Manual mode: value register starts masked.
// - Manual first value write drives all low.
// - Reset from supply pin, power-on, software.
// - Link follows serial register write framing.
`timescale 1ns/1ns
module rfx_expander
  import rfx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        address_select_pin,
  input  wire logic        init_config_pin,
  input  wire logic        interface_supply_reset_pin,
  input  wire logic        power_on_reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [7:0]  general_output,
  output logic      [7:0]  general_output_oe,
  output logic      [7:0]  pull_up_en,
  output logic      [7:0]  pull_dn_en
);

  logic        adr_s;
  logic        cfg_s;
  logic        supply_s;
  logic        por_s;
  logic        tog_s;
  logic        tog_seen_q;
  logic        rst_all;
  logic        rst_all_q;
  logic [1:0]  rst_tail_q;
  logic        soft_rst_q;
  logic        manual_mode_q;
  logic [3:0]  usid_q;
  logic        first_done_q;
  logic [7:0]  out_value_q;
  logic [7:0]  upd_mask_q;
  logic [7:0]  pull_dir_q;
  logic [7:0]  pull_on_q;
  logic [7:0]  drive_high_q;
  logic [7:0]  drive_en_q;
  logic        link_en_q;
  logic        link_en_s;
  rfx_wr_t     wr_word_q;
  rfx_wr_t     wr_word;
  logic        wr_toggle;
  logic        wr_stb;
  logic        wr_value;
  logic        cfg_write;
  rfx_pins_t   pins;
  logic        ahb_wr_q;
  logic [7:0]  ahb_addr_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  rfx_sync2 #(.W(5)) u_pin_sync (
    .clk (sys_clk),
    .d   ({address_select_pin, init_config_pin, interface_supply_reset_pin, power_on_reset, wr_toggle}),
    .q   ({adr_s, cfg_s, supply_s, por_s, tog_s})
  );

  rfx_sync2 #(.W(1)) u_en_sync (
    .clk (sclk),
    .d   (link_en_q),
    .q   (link_en_s)
  );

  // The link side only has a clock during frames, so its reset is asynchronous and driven from a flop here.
  rfx_link_rx u_link_rx (
    .sclk        (sclk),
    .link_rst    (rst_all_q),
    .sdata       (sdata),
    .link_en     (link_en_s),
    .usid        (usid_q),
    .wr_word_q   (wr_word),
    .wr_toggle_q (wr_toggle)
  );

  assign rst_all = srst || por_s || !supply_s || soft_rst_q;

  always_ff @(posedge sys_clk) begin
    rst_all_q  <= rst_all;
    rst_tail_q <= {rst_tail_q[0], rst_all_q};
  end

  // Software reset pulses for one cycle; only the system reset clears it so it cannot hold itself on.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_stb && wr_word_q.addr == LINK_TRIGGER && wr_word_q.data[SOFT_RESET_BIT];
    end
  end

  // Straps follow the pins throughout reset and freeze at its release.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      usid_q        <= adr_s ? USID_STRAP_HIGH : USID_STRAP_LOW;
      manual_mode_q <= cfg_s;
    end
  end

  // The word has been stable for the whole synchroniser delay when the toggle edge is seen.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      tog_seen_q <= tog_s;
      wr_word_q  <= '0;
    end else begin
      tog_seen_q <= tog_s;
      wr_word_q  <= wr_word;
    end
  end

  // The link clears its toggle under the reset copy, and that edge takes two more cycles to cross; ignore it.
  assign wr_stb    = (tog_s != tog_seen_q) && !rst_all && !rst_all_q && rst_tail_q == 2'h0;
  assign wr_value  = wr_stb && wr_word_q.addr == LINK_OUT_VALUE;
  assign cfg_write = wr_stb && manual_mode_q;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      first_done_q <= 1'b0;
    end else if (wr_value) begin
      first_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      upd_mask_q <= MASK_AUTO_RST;
    end else if (rst_all_q) begin
      upd_mask_q <= manual_mode_q ? MASK_MANUAL_RST : MASK_AUTO_RST;
    end else if (wr_stb && wr_word_q.addr == LINK_UPD_MASK) begin
      upd_mask_q <= wr_word_q.data;
    end
  end

  // The first manual write only wakes the drivers low; it loads no data.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      out_value_q <= OUT_VALUE_RST;
      drive_en_q  <= DRIVE_EN_RST;
    end else if (wr_value && manual_mode_q && !first_done_q) begin
      out_value_q <= OUT_VALUE_RST;
      drive_en_q  <= ~DRIVE_EN_RST;
    end else if (wr_value && !manual_mode_q) begin
      out_value_q <= (out_value_q & upd_mask_q) | (wr_word_q.data & ~upd_mask_q);
      drive_en_q  <= drive_en_q | ~upd_mask_q;
    end else if (wr_value) begin
      out_value_q <= (out_value_q & upd_mask_q) | (wr_word_q.data & ~upd_mask_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      pull_dir_q <= PULL_DIR_RST;
    end else if (cfg_write && wr_word_q.addr == LINK_PULL_DIR) begin
      pull_dir_q <= wr_word_q.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      pull_on_q <= PULL_ON_RST;
    end else if (wr_value && !manual_mode_q) begin
      pull_on_q <= pull_on_q & upd_mask_q;
    end else if (cfg_write && wr_word_q.addr == LINK_PULL_ON) begin
      pull_on_q <= wr_word_q.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      drive_high_q <= DRIVE_HIGH_RST;
    end else if (cfg_write && wr_word_q.addr == LINK_DRIVE_HIGH) begin
      drive_high_q <= wr_word_q.data;
    end
  end

  // Where drive_en_q is set, a low level is driven; a high level is driven only where full drive is configured, else high-z.
  for (genvar i = 0; i < OUT_COUNT; i++) begin : g_out
    always_ff @(posedge sys_clk) begin
      if (rst_all) begin
        pins.level[i]   <= 1'b0;
        pins.oe[i]      <= 1'b0;
        pins.pull_up[i] <= 1'b0;
        pins.pull_dn[i] <= 1'b1;
      end else begin
        pins.level[i]   <= out_value_q[i];
        pins.oe[i]      <= drive_en_q[i] && (!out_value_q[i] || drive_high_q[i]);
        pins.pull_up[i] <= pull_on_q[i] && pull_dir_q[i];
        pins.pull_dn[i] <= pull_on_q[i] && !pull_dir_q[i];
      end
    end
  end

  assign general_output    = pins.level;
  assign general_output_oe = pins.oe;
  assign pull_up_en        = pins.pull_up;
  assign pull_dn_en        = pins.pull_dn;

  // Software sees state here; output configuration itself is changed only from the link.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ahb_wr_q   <= 1'b0;
      ahb_addr_q <= 8'h00;
    end else if (hready) begin
      ahb_wr_q   <= hsel && htrans == HTRANS_NONSEQ && hwrite;
      ahb_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link_en_q <= CTRL_LINK_EN_RST;
    end else if (ahb_wr_q && ahb_addr_q == AHB_CTRL) begin
      link_en_q <= hwdata[0];
    end
  end

  always_comb begin
    rdata_d = 32'h00000000;
    case (haddr[7:0])
      AHB_CTRL:       rdata_d = {31'h00000000, link_en_q};
      AHB_STATUS:     rdata_d = {26'h0000000, manual_mode_q, usid_q, first_done_q};
      AHB_OUT_VALUE:  rdata_d = {24'h000000, out_value_q};
      AHB_UPD_MASK:   rdata_d = {24'h000000, upd_mask_q};
      AHB_PULL_DIR:   rdata_d = {24'h000000, pull_dir_q};
      AHB_PULL_ON:    rdata_d = {24'h000000, pull_on_q};
      AHB_DRIVE_HIGH: rdata_d = {24'h000000, drive_high_q};
      AHB_PIN_STATE:  rdata_d = pins;
      default:        rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= 32'h00000000;
    end else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  sequence s_first_manual;
    wr_value && manual_mode_q && !first_done_q;
  endsequence

  property p_usid;
    @(posedge sys_clk) disable iff (rst_all)
      usid_q == USID_STRAP_HIGH || usid_q == USID_STRAP_LOW;
  endproperty
  a_usid: assert property (p_usid) else $error("Identifier is neither strap value.");

  property p_reset_pins;
    @(posedge sys_clk) rst_all |=> pins.oe == 8'h00 && pins.pull_dn == 8'hff && pins.pull_up == 8'h00;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("Outputs not high-z with pull-down in reset.");

  property p_mask_start;
    @(posedge sys_clk) disable iff (srst)
      $fell(rst_all_q) |-> upd_mask_q == (manual_mode_q ? MASK_MANUAL_RST : MASK_AUTO_RST);
  endproperty
  a_mask_start: assert property (p_mask_start) else $error("Mask start value does not match mode.");

  property p_auto_drive;
    @(posedge sys_clk) disable iff (rst_all)
      wr_value && !manual_mode_q && upd_mask_q == 8'h00 |=> ##1 pins.oe == 8'hff && pins.pull_dn == 8'h00
        && pins.level == $past(wr_word_q.data, 2);
  endproperty
  a_auto_drive: assert property (p_auto_drive) else $error("Auto mode write did not drive outputs.");

  property p_auto_locked;
    @(posedge sys_clk) disable iff (rst_all)
      !manual_mode_q |=> $stable(pull_dir_q) && $stable(drive_high_q);
  endproperty
  a_auto_locked: assert property (p_auto_locked) else $error("Auto mode changed pull or drive setting.");

  property p_mask_hold;
    @(posedge sys_clk) disable iff (rst_all)
      wr_value |=> (out_value_q & $past(upd_mask_q)) == ($past(out_value_q) & $past(upd_mask_q));
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("Masked output changed on value write.");

  property p_first_manual;
    @(posedge sys_clk) disable iff (rst_all)
      s_first_manual |=> ##1 pins.level == 8'h00 && pins.oe == 8'hff && $stable(pull_on_q);
  endproperty
  a_first_manual: assert property (p_first_manual) else $error("First manual write did not drive low.");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (srst)
      soft_rst_q |=> rst_all_q ##1 drive_en_q == DRIVE_EN_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("Software reset did not reset logic.");

  property p_strap_hold;
    @(posedge sys_clk) !rst_all && !rst_all_q |-> $stable(usid_q) && $stable(manual_mode_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("Strap value changed outside reset.");

endmodule

// ===== dv/rfx_link_master.sv
`timescale 1ns/1ns
module rfx_link_master
  import rfx_pkg::*;
(
  output logic sclk,
  output logic sdata
);
  initial begin
    sclk  = 1'b0;
    sdata = 1'b0;
  end

  // The clock stands low between frames; a set bad flag breaks the first parity bit.
  task automatic send(input logic [3:0] sa, input logic [4:0] addr, input logic [7:0] data, input logic bad);
    logic [21:0] bits;
    bits = {sa, CMD_REG_WRITE, addr, (~^{sa, CMD_REG_WRITE, addr}) ^ bad, data, ~^data};
    #7;
    sdata = 1'b1;
    #80;
    sdata = 1'b0;
    #80;
    for (int i = 21; i >= 0; i--) begin
      sdata = bits[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    // The park edge leaves the line low, where it stays until the next frame starts.
    sdata = 1'b0;
    #80 sclk = 1'b1;
    #80 sclk = 1'b0;
  endtask
endmodule

// ===== dv/rfx_expander_tb.sv
`timescale 1ns/1ns
module rfx_expander_tb;
  import rfx_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        sclk;
  logic        sdata;
  logic        adr = 1'b1;
  logic        cfg = 1'b0;
  logic        supply_rst_n = 1'b1;
  logic        por = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  gout, goe, pup, pdn;
  logic [31:0] rd;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  localparam logic [31:0] PINS_RST = {8'h00, 8'hff, 8'h00, 8'h00};
  localparam logic [31:0] PINS_A5  = {8'h00, 8'h00, 8'hff, 8'ha5};

  assign hready = hreadyout;

  rfx_link_master rfx_link_master_i (.sclk(sclk), .sdata(sdata));

  rfx_expander rfx_expander_i (
    .sys_clk(sys_clk), .srst(srst), .sclk(sclk), .sdata(sdata), .address_select_pin(adr),
    .init_config_pin(cfg), .interface_supply_reset_pin(supply_rst_n), .power_on_reset(por), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .general_output(gout),
    .general_output_oe(goe), .pull_up_en(pup), .pull_dn_en(pdn)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The ceiling is several times the length of the planned traffic.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Pins are looked at on the falling edge, away from the edge that updates them.
  task automatic chk_pins(input string name, input logic [31:0] exp);
    @(negedge sys_clk);
    chk32(name, exp, {pup, pdn, goe, gout});
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk32(name, exp, r);
    chk32("response", 32'h0, {31'h0, hresp});
  endtask

  // The settle time covers the crossing and stays above the minimum frame spacing.
  task automatic frame(input logic [3:0] sa, input logic [4:0] addr, input logic [7:0] data, input logic bad);
    rfx_link_master_i.send(sa, addr, data, bad);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic do_reset(input logic a, input logic c);
    @(posedge sys_clk);
    srst <= 1'b1;
    adr  <= a;
    cfg  <= c;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    do_reset(1'b1, 1'b0);
    chk_pins("pins after reset", PINS_RST);
    rd_chk("status auto", AHB_STATUS, 32'h12);
    rd_chk("mask auto", AHB_UPD_MASK, {24'h0, MASK_AUTO_RST});
    rd_chk("ctrl", AHB_CTRL, {31'h0, CTRL_LINK_EN_RST});
    rd_chk("unmapped", 8'h40, 32'h0);
    ahb(1'b1, AHB_STATUS, 32'hff, rd);
    rd_chk("status after write", AHB_STATUS, 32'h12);
    frame(USID_STRAP_LOW, LINK_OUT_VALUE, 8'hff, 1'b0);
    chk_pins("foreign identifier", PINS_RST);
    frame(USID_STRAP_HIGH, LINK_OUT_VALUE, 8'hff, 1'b1);
    chk_pins("bad parity", PINS_RST);
    ahb(1'b1, AHB_CTRL, 32'h0, rd);
    frame(USID_STRAP_HIGH, LINK_OUT_VALUE, 8'hff, 1'b0);
    chk_pins("link disabled", PINS_RST);
    ahb(1'b1, AHB_CTRL, 32'h1, rd);
    frame(USID_STRAP_HIGH, LINK_PULL_ON, 8'h00, 1'b0);
    frame(USID_STRAP_HIGH, LINK_PULL_DIR, 8'hff, 1'b0);
    frame(USID_STRAP_HIGH, LINK_DRIVE_HIGH, 8'h00, 1'b0);
    chk_pins("auto pull writes", PINS_RST);
    rd_chk("auto pull dir", AHB_PULL_DIR, {24'h0, PULL_DIR_RST});
    rd_chk("auto drive high", AHB_DRIVE_HIGH, {24'h0, DRIVE_HIGH_RST});
    for (int s = 0; s < 3; s++) begin
      frame(USID_STRAP_HIGH, LINK_OUT_VALUE, 8'ha5, 1'b0);
      chk_pins("auto value write", PINS_A5);
      rd_chk("status seen", AHB_STATUS, 32'h13);
      if (s == 0) begin
        frame(USID_STRAP_HIGH, LINK_UPD_MASK, 8'h0f, 1'b0);
        frame(USID_STRAP_HIGH, LINK_OUT_VALUE, 8'h5a, 1'b0);
        chk_pins("masked value", {8'h00, 8'h00, 8'hff, 8'h55});
        frame(USID_STRAP_HIGH, LINK_TRIGGER, 8'h1 << SOFT_RESET_BIT, 1'b0);
      end else begin
        por          <= (s == 1);
        supply_rst_n <= (s != 2);
        repeat (4) @(posedge sys_clk);
        por          <= 1'b0;
        supply_rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
      end
      chk_pins("pins after reset source", PINS_RST);
    end
    do_reset(1'b0, 1'b1);
    adr <= 1'b1;
    cfg <= 1'b0;
    rd_chk("status manual", AHB_STATUS, 32'h22);
    rd_chk("mask manual", AHB_UPD_MASK, {24'h0, MASK_MANUAL_RST});
    frame(USID_STRAP_LOW, LINK_OUT_VALUE, 8'h55, 1'b0);
    chk_pins("manual first write", {8'h00, 8'hff, 8'hff, 8'h00});
    frame(USID_STRAP_LOW, LINK_PULL_DIR, 8'hff, 1'b0);
    frame(USID_STRAP_LOW, LINK_PULL_ON, 8'hff, 1'b0);
    frame(USID_STRAP_LOW, LINK_DRIVE_HIGH, 8'hff, 1'b0);
    frame(USID_STRAP_LOW, LINK_UPD_MASK, 8'h00, 1'b0);
    frame(USID_STRAP_LOW, LINK_OUT_VALUE, 8'h3c, 1'b0);
    chk_pins("manual configured", {8'hff, 8'h00, 8'hff, 8'h3c});
    frame(USID_BROADCAST, LINK_DRIVE_HIGH, 8'h0f, 1'b0);
    chk_pins("broadcast high-z", {8'hff, 8'h00, 8'hcf, 8'h3c});
    frame(USID_STRAP_LOW, LINK_UPD_MASK, 8'hf0, 1'b0);
    frame(USID_STRAP_LOW, LINK_OUT_VALUE, 8'h03, 1'b0);
    chk_pins("manual masked", {8'hff, 8'h00, 8'hcf, 8'h33});
    rd_chk("pin state", AHB_PIN_STATE, {8'hff, 8'h00, 8'hcf, 8'h33});
    rd_chk("value reg", AHB_OUT_VALUE, 32'h33);
    rd_chk("pull dir", AHB_PULL_DIR, 32'hff);
    rd_chk("pull on", AHB_PULL_ON, 32'hff);
    rd_chk("drive high", AHB_DRIVE_HIGH, 32'h0f);
    rd_chk("status held", AHB_STATUS, 32'h23);
    wrap_up();
  end
endmodule
